/* File: verilog/sac_map.vh */
`ifndef SAC_MAP_VH
`define SAC_MAP_VH
// Resolution and code points
`define SAC_BITS 16
`define SAC_CODE_ZERO 16'h0000
`define SAC_CODE_TOP 16'hffff
`define SAC_MSB_FLIP 16'h8000
// Timing
`define SAC_CLK_NS 8
`define SAC_ACQ_NS 400
`define SAC_STEP_NS 80
`endif

/* File: verilog/sac_conversion.v */
`timescale 1ns/100ps
`include "sac_map.vh"
// What this block does
// (R1) A falling edge on conversion_start_n begins a conversion.
// (R2) Stop tracking at conversion start; hold the sample throughout conversion.
// (R3) Binary search MSB first, one binary weight per step, down to one step.
// (R4) After the search, form the output code, then drop busy.
// (R5) Output coding is straight binary or twos complement per coding_select.
// (R6) Twos complement equals straight binary with the top bit inverted.
// (R7) Over-range saturates at FFFF straight binary, 7FFF twos complement.
// (R8) Under-range saturates at 0000 straight binary, 8000 twos complement.
// (R9) No pipeline delay: result belongs to this conversion's own sample.
// (R10) A running conversion ignores new start edges and power-down.
// (R11) Start held low after busy falls starts the next conversion automatically.
// (R12) Busy stays high from conversion start until the code is ready.
module sac_conversion #(
   parameter WIDTH = `SAC_BITS,
   parameter ACQ_NS = `SAC_ACQ_NS,
   parameter STEP_NS = `SAC_STEP_NS
) (
   input wire clk_sys, // System clock, 125 MHz
   input wire reset, // Asynchronous reset, active high
   input wire conversion_start_n, // Conversion start pin, active low
   input wire coding_select, // 1 straight binary, 0 twos complement
   input wire powerDown, // Power-down request pin
   input wire compAbove, // Comparator: held input at or above trial level
   input wire overRange, // Analog input above reference span
   input wire underRange, // Analog input below its ground
   output reg tracking_q, // High while the sampler tracks the input
   output reg [WIDTH-1:0] trialCode_q, // Capacitor switch pattern under trial
   output reg busy_q, // High during a conversion
   output reg [WIDTH-1:0] dataOut_q, // Result code
   output reg poweredDown_q // Converter core powered down
);
   // ***************************************
   // Timing
   // ***************************************
   localparam ACQ_CYC = (ACQ_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS;
   localparam STEP_CYC = (STEP_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS;
   // Sized copies for compares against the 16-bit timer
   localparam [15:0] ACQ_LIM = ACQ_CYC;
   localparam [15:0] STEP_LIM = STEP_CYC;

   // ***************************************
   // Sequencer states
   // ***************************************
   localparam [1:0] S_ACQ = 2'h0;
   localparam [1:0] S_READY = 2'h1;
   localparam [1:0] S_CONV = 2'h2;
   localparam [1:0] S_CODE = 2'h3;

   // ***************************************
   // Pin synchronisers
   // ***************************************
   reg [1:0] startSync_q;
   reg [1:0] codeSync_q;
   reg [1:0] pdSync_q;
   reg [1:0] cmpSync_q;
   reg [1:0] ovSync_q;
   reg [1:0] unSync_q;
   reg startPrev_q;

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         startSync_q <= 2'h3;
         codeSync_q <= 2'h3;
         pdSync_q <= 2'h0;
         cmpSync_q <= 2'h0;
         ovSync_q <= 2'h0;
         unSync_q <= 2'h0;
         startPrev_q <= 1'b1;
      end else begin
         startSync_q <= {startSync_q[0], conversion_start_n};
         codeSync_q <= {codeSync_q[0], coding_select};
         pdSync_q <= {pdSync_q[0], powerDown};
         cmpSync_q <= {cmpSync_q[0], compAbove};
         ovSync_q <= {ovSync_q[0], overRange};
         unSync_q <= {unSync_q[0], underRange};
         startPrev_q <= startSync_q[1];
      end
   end
   // ***************************************
   // Start pin edge and level
   // ***************************************
   wire startLow = ~startSync_q[1];
   wire startFall = startPrev_q & ~startSync_q[1];

   // ***************************************
   // Result coding
   // ***************************************
   // Straight binary to chosen coding, with saturation
   function [WIDTH-1:0] formCode;
      input [WIDTH-1:0] raw;
      input ov;
      input un;
      input straight;
      reg [WIDTH-1:0] sat;
      begin
         sat = raw;
         if (ov) begin
            sat = {WIDTH{1'b1}}; // [R7]
         end else if (un) begin
            sat = {WIDTH{1'b0}}; // [R8]
         end
         if (straight) begin
            formCode = sat; // [R5]
         end else begin
            // Only the top bit differs between the two codings
            formCode = {~sat[WIDTH-1], sat[WIDTH-2:0]}; // [R5] [R6]
         end
      end
   endfunction

   // ***************************************
   // Conversion sequencer
   // ***************************************
   reg [1:0] state_q;
   reg [15:0] timer_q;
   reg [WIDTH-1:0] bitMask_q;
   reg armed_q;
   reg ovHold_q;
   reg unHold_q;
   reg busyOnce_q;

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_q <= S_ACQ;
         timer_q <= 16'h0000;
         bitMask_q <= {WIDTH{1'b0}};
         trialCode_q <= {WIDTH{1'b0}};
         dataOut_q <= {WIDTH{1'b0}};
         busy_q <= 1'b0;
         tracking_q <= 1'b1;
         armed_q <= 1'b0;
         ovHold_q <= 1'b0;
         unHold_q <= 1'b0;
         poweredDown_q <= 1'b0;
      end else begin
         case (state_q)
            S_ACQ: begin
               tracking_q <= 1'b1;
               poweredDown_q <= pdSync_q[1];
               // Power-down status follows the pin only while idle [R10]
               if (timer_q < ACQ_LIM) begin
                  timer_q <= timer_q + 16'h0001;
               end else begin
                  state_q <= S_READY;
               end
               if (startFall) begin
                  armed_q <= 1'b1; // Early edge waits for acquisition end
               end
            end

            S_READY: begin
               poweredDown_q <= pdSync_q[1];
               // Power-down blocks the start while idle
               // Held-low start restarts only after first edge since reset
               if (~pdSync_q[1] & (startFall | armed_q | (startLow & busyOnce_q))) begin // [R1] [R11]
                  state_q <= S_CONV;
                  tracking_q <= 1'b0; // [R2]
                  busy_q <= 1'b1; // [R12]
                  ovHold_q <= ovSync_q[1]; // [R2]
                  unHold_q <= unSync_q[1];
                  bitMask_q <= {1'b1, {(WIDTH-1){1'b0}}}; // [R3]
                  trialCode_q <= {1'b1, {(WIDTH-1){1'b0}}};
                  timer_q <= 16'h0000;
                  armed_q <= 1'b0;
               end
            end

            S_CONV: begin
               // Start edges and power-down are not looked at here [R10]
               if (timer_q < STEP_LIM) begin
                  timer_q <= timer_q + 16'h0001;
               end else begin
                  timer_q <= 16'h0000;
                  if (bitMask_q[0]) begin
                     // Last weight decided; code forms next cycle
                     state_q <= S_CODE;
                     if (~cmpSync_q[1]) begin
                        trialCode_q <= trialCode_q & ~bitMask_q;
                     end
                  end else begin
                     // Keep or drop this bit, then try the next lower weight [R3]
                     if (cmpSync_q[1]) begin
                        trialCode_q <= trialCode_q | (bitMask_q >> 1);
                     end else begin
                        trialCode_q <= (trialCode_q & ~bitMask_q) | (bitMask_q >> 1);
                     end
                     bitMask_q <= bitMask_q >> 1;
                  end
               end
            end

            S_CODE: begin
               dataOut_q <= formCode(trialCode_q, ovHold_q, unHold_q, codeSync_q[1]); // [R4] [R9]
               busy_q <= 1'b0; // [R4] [R12]
               tracking_q <= 1'b1;
               timer_q <= 16'h0000;
               state_q <= S_ACQ;
            end

            default: begin
               state_q <= S_ACQ;
            end
         endcase
      end
   end

   // ***************************************
   // Auto-restart enable
   // ***************************************
   // Marks that a conversion has run, enabling self-restart on a held-low start
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         busyOnce_q <= 1'b0;
      end else if (busy_q) begin
         busyOnce_q <= 1'b1; // [R11]
      end
   end
endmodule

/* File: tb/sac_front.sv */
`timescale 1ns/100ps
// ********
// Sampler and comparator stand-in
// ********
module sac_front (
   input wire clk_sys, // Clock
   input wire tracking_q, // Sampler tracks while high
   input wire [15:0] trialCode_q, // Trial level
   input wire [15:0] level, // Input level in steps
   output logic compAbove // Held level at or above trial
);
   logic [15:0] heldLevel_q;
   always @(posedge clk_sys) if (tracking_q) heldLevel_q <= level;
   assign compAbove = heldLevel_q >= trialCode_q;
endmodule

/* File: tb/sac_conversion_props.sv */
`timescale 1ns/100ps
// ********
// Conversion timing and code checks
// ********
module sac_conversion_props #(parameter WIDTH = 16) (
   input wire clk_sys, // Clock
   input wire reset, // Reset
   input wire coding_select, // Coding
   input wire overRange, // Over
   input wire underRange, // Under
   input wire tracking_q, // Tracking
   input wire [WIDTH-1:0] trialCode_q, // Trial
   input wire busy_q, // Busy
   input wire [WIDTH-1:0] dataOut_q // Result
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   sequence s_msbOnly;
      trialCode_q == 16'h8000 && !tracking_q;
   endsequence
   sequence s_nextBit;
      (trialCode_q[14:0] == 15'h0000) [*8] ##[3:5] trialCode_q[14];
   endsequence
   a_msb_trial_first: assert property ($rose(busy_q) |-> s_msbOnly)
      else $error("first trial not msb");
   a_search_step_down: assert property ($rose(busy_q) |-> s_nextBit)
      else $error("second trial missing");
   a_busy_span: assert property ($rose(busy_q) |-> ##176 busy_q ##1 !busy_q)
      else $error("busy length wrong");
   a_busy_no_track: assert property (busy_q |-> !tracking_q)
      else $error("tracking during conversion");
   a_result_held: assert property (!$fell(busy_q) |-> $stable(dataOut_q))
      else $error("result changed mid run");
   a_acq_gap: assert property ($fell(busy_q) |-> !busy_q [*8])
      else $error("restart too soon");
   a_over_code: assert property ($fell(busy_q) && overRange
      |-> dataOut_q == (coding_select ? 16'hffff : 16'h7fff)) else $error("over code");
   a_under_code: assert property ($fell(busy_q) && underRange && !overRange
      |-> dataOut_q == (coding_select ? 16'h0000 : 16'h8000)) else $error("under code");
endmodule
bind sac_conversion sac_conversion_props #(.WIDTH(WIDTH)) u_props (.clk_sys(clk_sys),
   .reset(reset), .coding_select(coding_select), .overRange(overRange),
   .underRange(underRange), .tracking_q(tracking_q), .trialCode_q(trialCode_q),
   .busy_q(busy_q), .dataOut_q(dataOut_q));

/* File: tb/sac_conversion_bench.sv */
`timescale 1ns/100ps
module sac_conversion_bench;
   logic clk_sys = 0, reset = 1, startN = 1, codeSel = 0, pd = 0, ov = 0, un = 0;
   logic compAbove, tracking, busy, pdOut;
   logic [15:0] trial, dout, level = 16'h0000;
   int n_errors = 0, comparisons = 0;
   sac_conversion u_sac_conversion (.clk_sys(clk_sys), .reset(reset),
      .conversion_start_n(startN), .coding_select(codeSel), .powerDown(pd),
      .compAbove(compAbove), .overRange(ov), .underRange(un), .tracking_q(tracking),
      .trialCode_q(trial), .busy_q(busy), .dataOut_q(dout), .poweredDown_q(pdOut));
   sac_front u_sac_front (.clk_sys(clk_sys), .tracking_q(tracking), .trialCode_q(trial),
      .level(level), .compAbove(compAbove));
   initial forever #4 clk_sys = ~clk_sys;
   task give_verdict;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task waitBusy(input logic lvl);
      int i;
      for (i = 0; i < 400 && busy !== lvl; i++) @(negedge clk_sys);
      check(busy === lvl, "busy wait ran out");
      if (busy !== lvl) give_verdict();
   endtask
   function logic [15:0] model(input logic [15:0] lv, input logic o, u, s);
      model = o ? 16'hffff : u ? 16'h0000 : lv;
      if (!s) model = model ^ 16'h8000;
   endfunction
   // ********
   // Conversions: code points, ranges, ignored starts, auto restart
   // ********
   task convert(input logic [15:0] lv, input logic o, u, s, hold);
      @(negedge clk_sys);
      level = lv; ov = o; un = u; codeSel = s; startN = 0;
      waitBusy(1);
      level = ~lv; startN = 1; pd = 1; // Sample must not follow this
      repeat (20) @(negedge clk_sys);
      check(pdOut === 1'b0, "power-down taken mid run");
      startN = 0;
      @(negedge clk_sys);
      startN = ~hold;
      waitBusy(0);
      pd = 0;
      check(dout === model(lv, o, u, s), "code");
      if (hold) begin
         waitBusy(1);
         startN = 1;
         waitBusy(0);
         check(dout === model(~lv, o, u, s), "auto code");
      end else begin
         repeat (60) @(negedge clk_sys);
         check(busy === 1'b0, "late edge started");
      end
   endtask
   initial begin
      logic [15:0] lv;
      int k;
      void'($urandom(32'h7c6b57da));
      repeat (16) @(posedge clk_sys);
      @(negedge clk_sys) reset = 0;
      for (k = 0; k < 12; k++) begin
         lv = k < 4 ? {k[0], 15'h0000} - 16'(k[1]) : 16'($urandom);
         convert(lv, k > 3 && k % 4 == 1, k > 3 && k % 4 == 2, 1'($urandom), k % 3 == 2);
      end
      give_verdict();
   end
endmodule
